// >>> verification/kil_keypad_switches.sv
`timescale 1ns/1ps
// Keys on the port pins: a pressed key pulls its pin low
module kil_keypad_switches
(
	// Clock
	input wire logic clk,
	// Keys and port drive
	input wire logic [7:0] keys,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pullup_en,
	// Resolved pin levels
	output logic [7:0] level
);
	logic [7:0] float_r = 8'h55;
	// An undriven pin without pullup wanders every cycle
	always_ff @(posedge clk)
		float_r <= ~float_r;
	// Port drive wins, else key low, else pullup
	assign level = (pin_oe & pin_out) | (~pin_oe & ~keys & (pullup_en | float_r));
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ps
// Register-level tests of the keypad latch
module testbench;
	logic clk = 0;
	logic resetn = 0;
	kil_pkg::kil_bus_type bus = '0;
	logic [7:0] rdata, pin_out, pin_oe, pullup_en, level;
	logic [7:0] keys = 8'h00;
	logic vfetch = 0, brk = 0, bce = 0, irq, wake;
	logic [15:0] faddr = 16'h0000;
	int err_count = 0, total_checks = 0, cyc = 0;

	kil_keypad_latch dut (.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata),
		.vector_fetch(vfetch), .fetch_addr(faddr), .irq(irq), .wake(wake),
		.break_state(brk), .break_clear_enable(bce), .port_a_pin_in(level),
		.port_a_pin_out(pin_out), .port_a_pin_oe(pin_oe), .pullup_en(pullup_en));
	kil_keypad_switches sw (.clk(clk), .keys(keys), .pin_out(pin_out), .pin_oe(pin_oe),
		.pullup_en(pullup_en), .level(level));

	// Clock and hang guard
	initial
	begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_count++;
			test_done;
		end
	end

	// Verdict and end of run
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Compare one byte
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One write cycle
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	// One read cycle; data stand in the next cycle only
	task automatic rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	// Set the keys and let the synchroniser settle
	task automatic press(input logic [7:0] k);
		@(posedge clk);
		keys <= k;
		repeat (6) @(posedge clk);
	endtask

	// Main sequence
	initial
	begin
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		rd(2'h0, 8'h00);
		rd(2'h1, 8'h00);
		wr(2'h0, 8'h02);
		wr(2'h1, 8'hFF);
		wr(2'h0, 8'h06);
		wr(2'h0, 8'h00);
		rd(2'h1, 8'hFF);
		chk(pullup_en, 8'hFF);
		chk(pin_oe, 8'h00);
		// Edge mode: latch, acknowledge, blocked edge, new edge, vector fetch
		press(8'h01);
		rd(2'h0, 8'h08);
		chk({7'h00, wake}, 8'h01);
		wr(2'h0, 8'h04);
		rd(2'h0, 8'h00);
		press(8'h03);
		rd(2'h0, 8'h00);
		press(8'h00);
		press(8'h10);
		rd(2'h0, 8'h08);
		@(posedge clk);
		vfetch <= 1'b1;
		faddr <= 16'hFFE0;
		@(posedge clk);
		vfetch <= 1'b0;
		rd(2'h0, 8'h00);
		press(8'h00);
		// Masked request still flagged; break gates the acknowledge
		wr(2'h0, 8'h02);
		press(8'h20);
		rd(2'h0, 8'h0A);
		chk({7'h00, irq}, 8'h00);
		@(posedge clk);
		brk <= 1'b1;
		wr(2'h0, 8'h06);
		rd(2'h0, 8'h0A);
		@(posedge clk);
		bce <= 1'b1;
		wr(2'h0, 8'h06);
		brk <= 1'b0;
		rd(2'h0, 8'h02);
		// Level mode, acknowledge before and after release
		wr(2'h0, 8'h01);
		press(8'h04);
		wr(2'h0, 8'h05);
		rd(2'h0, 8'h09);
		press(8'h00);
		rd(2'h0, 8'h01);
		press(8'h40);
		press(8'h00);
		rd(2'h0, 8'h09);
		wr(2'h0, 8'h05);
		rd(2'h0, 8'h01);
		wr(2'h0, 8'hF0);
		rd(2'h0, 8'h00);
		// Pins driven high first, then enabled; direction gates the pin read
		wr(2'h0, 8'h02);
		wr(2'h1, 8'h00);
		wr(2'h2, 8'hFF);
		wr(2'h3, 8'hFF);
		rd(2'h3, 8'hFF);
		chk(pin_oe, 8'hFF);
		chk(pin_out, 8'hFF);
		wr(2'h1, 8'hFF);
		press(8'h80);
		rd(2'h3, 8'hFF);
		wr(2'h2, 8'h00);
		rd(2'h3, 8'h7F);
		chk(pin_oe, 8'h00);
		press(8'h00);
		rd(2'h0, 8'h0A);
		// Reset while a key is held
		wr(2'h0, 8'h01);
		press(8'h08);
		resetn <= 1'b0;
		@(posedge clk);
		chk({7'h00, irq}, 8'h00);
		resetn <= 1'b1;
		rd(2'h0, 8'h00);
		rd(2'h1, 8'h00);
		chk(pullup_en, 8'h00);
		test_done;
	end
endmodule

// >>> verilog/kil_keypad_latch.sv
`timescale 1ns/1ps
// Summary of operation
// - Eight enable bits select keypad pins; reset clears
// - Enabled pin switches on its pullup
// - Latch when enabled pins fall from all-high
// - Edge mode ignores edge while another low
// - Level mode holds request while any low
// - Level mode clears after acknowledge and release
// - Vector fetch acknowledge clears latched request
// - Write-one acknowledge clears; reads zero
// - Acknowledge leaves later edge detection intact
// - Service fetches vector pair FFE0/FFE1
// - Edge mode acknowledge clears at once
// - Reset clears request and trigger mode
// - Pending flag shows latch, ignores mask
// - Enable forces input; read needs direction zero
// - Mask blocks forwarding; read/write; reset clears
// - Trigger bit: one level, zero edge
// - Upper four status bits read zero
// - Works in wait and stop; wakes
// - Break blocks software acknowledge unless clear enabled
module kil_keypad_latch
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register port
	input wire kil_pkg::kil_bus_type bus,
	output logic [7:0] rdata,
	// Processor side
	input wire logic vector_fetch,
	input wire logic [15:0] fetch_addr,
	output logic irq,
	output logic wake,
	// System integration
	input wire logic break_state,
	input wire logic break_clear_enable,
	// Port A pins
	input wire logic [7:0] port_a_pin_in,
	output logic [7:0] port_a_pin_out,
	output logic [7:0] port_a_pin_oe,
	output logic [7:0] pullup_en
);
	kil_pkg::kil_state_type st_r;
	kil_pkg::kil_state_type st_nxt;

	logic all_high_now;
	logic new_fall;
	logic sw_ack;
	logic vec_ack;
	logic ack;
	logic [7:0] read_val;
	logic [7:0] pin_view;

	// Event decode shared by next state and assertions
	always_comb
	begin
		all_high_now = kil_pkg::all_enabled_high(st_r.pin_sync2, st_r.keypad_pin_enables);
		new_fall = st_r.all_high_prev && !all_high_now;
		sw_ack = bus.wr && bus.addr == kil_pkg::ADDR_STATUS_CONTROL
			&& bus.wdata[kil_pkg::BIT_REQUEST_CLEAR]
			&& (!break_state || break_clear_enable);
		vec_ack = vector_fetch && fetch_addr == kil_pkg::VECTOR_ADDR_HIGH
			&& st_r.irq;
		ack = sw_ack || vec_ack;
	end

	// Next state of the whole block
	always_comb
	begin
		st_nxt = st_r;
		// Two-stage synchroniser on the pins
		st_nxt.pin_sync1 = port_a_pin_in;
		st_nxt.pin_sync2 = st_r.pin_sync1;
		st_nxt.all_high_prev = all_high_now;
		// Register writes
		if (bus.wr)
		begin
			unique case (bus.addr)
				kil_pkg::ADDR_STATUS_CONTROL:
				begin
					st_nxt.keypad_trigger_sel = bus.wdata[kil_pkg::BIT_TRIGGER_SEL];
					st_nxt.keypad_request_mask = bus.wdata[kil_pkg::BIT_REQUEST_MASK];
				end
				kil_pkg::ADDR_PIN_ENABLE:
					st_nxt.keypad_pin_enables = bus.wdata;
				kil_pkg::ADDR_PORT_DIRECTION:
					st_nxt.port_a_direction = bus.wdata;
				kil_pkg::ADDR_PORT_DATA:
					st_nxt.port_data = bus.wdata;
			endcase
		end
		// Request latch; a new edge wins over an acknowledge
		if (st_r.keypad_trigger_sel)
		begin
			// Level mode: clear needs both acknowledge and release
			if (ack)
				st_nxt.ack_seen = 1'b1;
			if (!all_high_now)
				st_nxt.latch = 1'b1;
			else if (st_r.ack_seen || ack)
				st_nxt.latch = 1'b0;
			if (new_fall)
				st_nxt.ack_seen = ack;
			if (all_high_now && (st_r.ack_seen || ack))
				st_nxt.ack_seen = 1'b0;
		end
		else
		begin
			st_nxt.ack_seen = 1'b0;
			if (new_fall)
				st_nxt.latch = 1'b1;
			else if (ack)
				st_nxt.latch = 1'b0;
		end
		// Outputs
		st_nxt.irq = st_nxt.latch && !st_nxt.keypad_request_mask;
		st_nxt.wake = st_nxt.irq;
		st_nxt.pullup_en = st_nxt.keypad_pin_enables;
		st_nxt.pin_oe = st_nxt.port_a_direction & ~st_nxt.keypad_pin_enables;
		st_nxt.pin_out = st_nxt.port_data;
		st_nxt.rdata = 8'h00;
		if (bus.rd)
			st_nxt.rdata = read_val;
	end

	// Read mux; acknowledge and upper bits read zero
	always_comb
	begin
		pin_view = (st_r.pin_sync2 & ~st_r.port_a_direction)
			| (st_r.port_data & st_r.port_a_direction);
		read_val = 8'h00;
		unique case (bus.addr)
			kil_pkg::ADDR_STATUS_CONTROL:
			begin
				read_val[kil_pkg::BIT_TRIGGER_SEL] = st_r.keypad_trigger_sel;
				read_val[kil_pkg::BIT_REQUEST_MASK] = st_r.keypad_request_mask;
				read_val[kil_pkg::BIT_PENDING_FLAG] = st_r.latch;
			end
			kil_pkg::ADDR_PIN_ENABLE:
				read_val = st_r.keypad_pin_enables;
			kil_pkg::ADDR_PORT_DIRECTION:
				read_val = st_r.port_a_direction;
			kil_pkg::ADDR_PORT_DATA:
				read_val = pin_view;
		endcase
	end

	// State register; reset clears request and mode
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_r <= '0;
			st_r.pin_sync1 <= kil_pkg::PINS_ALL_HIGH;
			st_r.pin_sync2 <= kil_pkg::PINS_ALL_HIGH;
			st_r.all_high_prev <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	assign rdata = st_r.rdata;
	assign irq = st_r.irq;
	assign wake = st_r.wake;
	assign port_a_pin_out = st_r.pin_out;
	assign port_a_pin_oe = st_r.pin_oe;
	assign pullup_en = st_r.pullup_en;

	// Checks
	a_edge_latches: assert property (@(posedge clk) disable iff (!resetn)
		new_fall |=> st_r.latch) else $error("falling edge not latched");
	a_edge_ack_clears: assert property (@(posedge clk) disable iff (!resetn)
		(ack && !new_fall && !st_r.keypad_trigger_sel && !(bus.wr && bus.addr ==
		kil_pkg::ADDR_STATUS_CONTROL)) |=> !st_r.latch) else $error("edge ack failed");
	a_level_holds: assert property (@(posedge clk) disable iff (!resetn)
		(st_r.keypad_trigger_sel && !all_high_now && !bus.wr) |=> st_r.latch)
		else $error("level request dropped");
	a_mask_blocks: assert property (@(posedge clk) disable iff (!resetn)
		st_r.keypad_request_mask |-> !st_r.irq) else $error("masked request forwarded");
	a_break_protects: assert property (@(posedge clk) disable iff (!resetn)
		(break_state && !break_clear_enable && !vec_ack && st_r.latch
		&& !(st_r.keypad_trigger_sel && st_r.ack_seen))
		|=> st_r.latch) else $error("break ack had effect");
	a_upper_zero: assert property (@(posedge clk) disable iff (!resetn)
		$past(bus.rd && bus.addr == kil_pkg::ADDR_STATUS_CONTROL)
		|-> rdata[7:4] == 4'h0 && !rdata[kil_pkg::BIT_REQUEST_CLEAR])
		else $error("reserved bits nonzero");
	a_pullup_follows: assert property (@(posedge clk) disable iff (!resetn)
		(bus.wr && bus.addr == kil_pkg::ADDR_PIN_ENABLE) |=> ##1
		pullup_en == $past(bus.wdata, 2)) else $error("pullup mismatch");
	a_enable_input: assert property (@(posedge clk) disable iff (!resetn)
		(port_a_pin_oe & pullup_en) == 8'h00) else $error("enabled pin driven");
	a_flag_mask_free: assert property (@(posedge clk) disable iff (!resetn)
		$past(bus.rd && bus.addr == kil_pkg::ADDR_STATUS_CONTROL)
		|-> rdata[kil_pkg::BIT_PENDING_FLAG] == $past(st_r.latch))
		else $error("pending flag wrong");

	// Forwarded request is exactly latch and not mask
	a_irq_is_latch: assert property (@(posedge clk) disable iff (!resetn)
		irq == (st_r.latch && !st_r.keypad_request_mask))
		else $error("irq does not follow latch and mask");

	// Wake line mirrors the forwarded request
	a_wake_tracks: assert property (@(posedge clk) disable iff (!resetn)
		wake == irq)
		else $error("wake differs from irq");

	// An unmasked latched request must wake the core
	a_unmasked_wakes: assert property (@(posedge clk) disable iff (!resetn)
		(st_r.latch && !st_r.keypad_request_mask) |-> wake)
		else $error("unmasked request gives no wake");

	// A masked request must never wake the core
	a_mask_no_wake: assert property (@(posedge clk) disable iff (!resetn)
		st_r.keypad_request_mask |-> !wake)
		else $error("masked request wakes core");

	// Pullups follow the enable register
	a_pullup_equals: assert property (@(posedge clk) disable iff (!resetn)
		pullup_en == st_r.keypad_pin_enables)
		else $error("pullup differs from enables");

	// Enabled pins never drive, direction decides the rest
	a_oe_override: assert property (@(posedge clk) disable iff (!resetn)
		port_a_pin_oe == (st_r.port_a_direction & ~st_r.keypad_pin_enables))
		else $error("output enable wrong");

	// Port drive comes from the data latch
	a_out_data: assert property (@(posedge clk) disable iff (!resetn)
		port_a_pin_out == st_r.port_data)
		else $error("pin drive differs from data latch");

	// Enable write lands next cycle
	a_en_write: assert property (@(posedge clk) disable iff (!resetn)
		(bus.wr && bus.addr == kil_pkg::ADDR_PIN_ENABLE)
		|=> st_r.keypad_pin_enables == $past(bus.wdata))
		else $error("enable write lost");

	// Enables hold without a write
	a_en_kept: assert property (@(posedge clk) disable iff (!resetn)
		!(bus.wr && bus.addr == kil_pkg::ADDR_PIN_ENABLE)
		|=> $stable(st_r.keypad_pin_enables))
		else $error("enables changed without write");

	// Trigger mode write lands next cycle
	a_mode_write: assert property (@(posedge clk) disable iff (!resetn)
		(bus.wr && bus.addr == kil_pkg::ADDR_STATUS_CONTROL)
		|=> st_r.keypad_trigger_sel == $past(bus.wdata[kil_pkg::BIT_TRIGGER_SEL]))
		else $error("trigger mode write lost");

	// Trigger mode holds without a write
	a_mode_kept: assert property (@(posedge clk) disable iff (!resetn)
		!(bus.wr && bus.addr == kil_pkg::ADDR_STATUS_CONTROL)
		|=> $stable(st_r.keypad_trigger_sel))
		else $error("trigger mode changed without write");

	// Mask write lands next cycle
	a_mask_write: assert property (@(posedge clk) disable iff (!resetn)
		(bus.wr && bus.addr == kil_pkg::ADDR_STATUS_CONTROL)
		|=> st_r.keypad_request_mask == $past(bus.wdata[kil_pkg::BIT_REQUEST_MASK]))
		else $error("mask write lost");

	// Mask holds without a write
	a_mask_kept: assert property (@(posedge clk) disable iff (!resetn)
		!(bus.wr && bus.addr == kil_pkg::ADDR_STATUS_CONTROL)
		|=> $stable(st_r.keypad_request_mask))
		else $error("mask changed without write");

	// Direction write lands next cycle
	a_dir_write: assert property (@(posedge clk) disable iff (!resetn)
		(bus.wr && bus.addr == kil_pkg::ADDR_PORT_DIRECTION)
		|=> st_r.port_a_direction == $past(bus.wdata))
		else $error("direction write lost");

	// Data latch write lands next cycle
	a_data_write: assert property (@(posedge clk) disable iff (!resetn)
		(bus.wr && bus.addr == kil_pkg::ADDR_PORT_DATA)
		|=> st_r.port_data == $past(bus.wdata))
		else $error("data write lost");

	// Read data stand only in the cycle after a read
	a_rdata_idle: assert property (@(posedge clk) disable iff (!resetn)
		!bus.rd |=> rdata == 8'h00)
		else $error("read data without read");

	// Enable register reads back
	a_rdata_enable: assert property (@(posedge clk) disable iff (!resetn)
		(bus.rd && bus.addr == kil_pkg::ADDR_PIN_ENABLE)
		|=> rdata == $past(st_r.keypad_pin_enables))
		else $error("enable readback wrong");

	// Direction register reads back
	a_rdata_direction: assert property (@(posedge clk) disable iff (!resetn)
		(bus.rd && bus.addr == kil_pkg::ADDR_PORT_DIRECTION)
		|=> rdata == $past(st_r.port_a_direction))
		else $error("direction readback wrong");

	// Port read shows pins only where direction is zero
	a_rdata_port: assert property (@(posedge clk) disable iff (!resetn)
		(bus.rd && bus.addr == kil_pkg::ADDR_PORT_DATA)
		|=> rdata == $past(pin_view))
		else $error("port readback wrong");

	// Trigger mode reads back
	a_rdata_mode: assert property (@(posedge clk) disable iff (!resetn)
		(bus.rd && bus.addr == kil_pkg::ADDR_STATUS_CONTROL)
		|=> rdata[kil_pkg::BIT_TRIGGER_SEL] == $past(st_r.keypad_trigger_sel))
		else $error("trigger mode readback wrong");

	// Mask reads back
	a_rdata_mask: assert property (@(posedge clk) disable iff (!resetn)
		(bus.rd && bus.addr == kil_pkg::ADDR_STATUS_CONTROL)
		|=> rdata[kil_pkg::BIT_REQUEST_MASK] == $past(st_r.keypad_request_mask))
		else $error("mask readback wrong");

	// Level mode: acknowledge with pins high clears at once
	a_level_ack_release: assert property (@(posedge clk) disable iff (!resetn)
		(st_r.keypad_trigger_sel && all_high_now && ack) |=> !st_r.latch)
		else $error("level clear after ack failed");

	// Level mode: acknowledge while low is remembered
	a_level_ack_pending: assert property (@(posedge clk) disable iff (!resetn)
		(st_r.keypad_trigger_sel && !all_high_now && ack) |=> st_r.ack_seen)
		else $error("early ack forgotten");

	// Level mode: release after acknowledge clears
	a_level_late_release: assert property (@(posedge clk) disable iff (!resetn)
		(st_r.keypad_trigger_sel && all_high_now && st_r.ack_seen) |=> !st_r.latch)
		else $error("release after ack did not clear");

	// Level mode: release without acknowledge keeps the request
	a_level_no_early_clear: assert property (@(posedge clk) disable iff (!resetn)
		(st_r.keypad_trigger_sel && all_high_now && !st_r.ack_seen && !ack && st_r.latch)
		|=> st_r.latch)
		else $error("level request cleared without ack");

	// Level mode: release consumes a remembered acknowledge
	a_level_seen_cleared: assert property (@(posedge clk) disable iff (!resetn)
		(st_r.keypad_trigger_sel && all_high_now) |=> !st_r.ack_seen)
		else $error("stale ack kept after release");

	// Edge mode: request holds until acknowledged
	a_edge_hold: assert property (@(posedge clk) disable iff (!resetn)
		(!st_r.keypad_trigger_sel && !new_fall && !ack && st_r.latch) |=> st_r.latch)
		else $error("edge request lost");

	// Edge mode: no request without a falling edge
	a_edge_no_level: assert property (@(posedge clk) disable iff (!resetn)
		(!st_r.keypad_trigger_sel && !new_fall && !st_r.latch) |=> !st_r.latch)
		else $error("edge mode latched on level");

	// Edge mode keeps no remembered acknowledge
	a_edge_seen_zero: assert property (@(posedge clk) disable iff (!resetn)
		!st_r.keypad_trigger_sel |=> !st_r.ack_seen)
		else $error("edge mode kept ack");

	// A new edge beats a simultaneous acknowledge
	a_new_edge_wins: assert property (@(posedge clk) disable iff (!resetn)
		(!st_r.keypad_trigger_sel && new_fall && ack) |=> st_r.latch)
		else $error("edge lost to ack");

	// Software acknowledge clears an edge request
	a_sw_ack_edge: assert property (@(posedge clk) disable iff (!resetn)
		(sw_ack && !st_r.keypad_trigger_sel && !new_fall) |=> !st_r.latch)
		else $error("software ack failed");

	// Vector fetch of the keypad vector clears an edge request
	a_vector_clears: assert property (@(posedge clk) disable iff (!resetn)
		(vector_fetch && fetch_addr == kil_pkg::VECTOR_ADDR_HIGH && st_r.irq
		&& !st_r.keypad_trigger_sel && !new_fall) |=> !st_r.latch)
		else $error("vector fetch did not clear");

	// Break without clear enable blocks the software acknowledge
	a_break_blocks_sw: assert property (@(posedge clk) disable iff (!resetn)
		(break_state && !break_clear_enable) |-> !sw_ack)
		else $error("ack accepted in break");

	// Break with clear enable lets the acknowledge clear
	a_break_open: assert property (@(posedge clk) disable iff (!resetn)
		(break_state && break_clear_enable && sw_ack && !st_r.keypad_trigger_sel
		&& !new_fall) |=> !st_r.latch)
		else $error("enabled break ack had no effect");

	// First synchroniser stage takes the pins
	a_sync_first: assert property (@(posedge clk) disable iff (!resetn)
		1'b1 |=> st_r.pin_sync1 == $past(port_a_pin_in))
		else $error("first sync stage wrong");

	// Second stage reads only the first
	a_sync_chain: assert property (@(posedge clk) disable iff (!resetn)
		1'b1 |=> st_r.pin_sync2 == $past(st_r.pin_sync1))
		else $error("second sync stage wrong");

	// Edge detector remembers the previous all-high state
	a_prev_high: assert property (@(posedge clk) disable iff (!resetn)
		1'b1 |=> st_r.all_high_prev == $past(all_high_now))
		else $error("edge history wrong");
endmodule

// >>> verilog/kil_pkg.sv
package kil_pkg;
	// Register indices on the plain register port
	localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_PIN_ENABLE = 2'h1;
	localparam logic [1:0] ADDR_PORT_DIRECTION = 2'h2;
	localparam logic [1:0] ADDR_PORT_DATA = 2'h3;
	// Status and control field positions
	localparam int BIT_TRIGGER_SEL = 0;
	localparam int BIT_REQUEST_MASK = 1;
	localparam int BIT_REQUEST_CLEAR = 2;
	localparam int BIT_PENDING_FLAG = 3;
	// Values after reset
	localparam logic [7:0] RESET_PIN_ENABLES = 8'h00;
	localparam logic [7:0] RESET_DIRECTION = 8'h00;
	localparam logic [7:0] RESET_DATA = 8'h00;
	localparam logic [7:0] PINS_ALL_HIGH = 8'hFF;
	// Vector pair fetched when the request is serviced
	localparam logic [15:0] VECTOR_ADDR_HIGH = 16'hFFE0;
	localparam logic [15:0] VECTOR_ADDR_LOW = 16'hFFE1;

	// Register bus request
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} kil_bus_type;

	// Complete state of the block
	typedef struct packed {
		logic [7:0] pin_sync1;
		logic [7:0] pin_sync2;
		logic all_high_prev;
		logic [7:0] keypad_pin_enables;
		logic [7:0] port_a_direction;
		logic [7:0] port_data;
		logic keypad_trigger_sel;
		logic keypad_request_mask;
		logic latch;
		logic ack_seen;
		logic [7:0] rdata;
		logic irq;
		logic wake;
		logic [7:0] pin_out;
		logic [7:0] pin_oe;
		logic [7:0] pullup_en;
	} kil_state_type;

	// Function used by the event decode for next state and assertions: enabled pins all high
	function automatic logic all_enabled_high(input logic [7:0] pins, input logic [7:0] en);
		all_enabled_high = &(pins | ~en);
	endfunction
endpackage
